// >>> inc/isa_four_pkg.sv
// Purpose: Shared constants and carriers for the instruction set attribute register four
// Assumes: One 200 MHz clock domain, answers one cycle after a request
// Notes: Every field value and encoding of the register is defined here; the field assertions and the testbench repeat them by hand
`default_nettype none
package isa_four_pkg;

  // System control coprocessor encoding that selects the register
  localparam logic [3:0] CP_NUM = 4'hF;
  localparam logic [2:0] CP_OPC1 = 3'h0;
  localparam logic [3:0] CP_CRN = 4'h0;
  localparam logic [3:0] CP_CRM = 4'h2;
  localparam logic [2:0] CP_OPC2 = 3'h4;

  // Privilege levels as carried on the request
  localparam logic [1:0] PL_ZERO = 2'h0;
  localparam logic [1:0] PL_ONE = 2'h1;

  // Field geometry
  localparam int FIELD_W = 4;
  localparam int FIELD_CNT = 8;
  localparam int SWAP_LOCK_LSB = 28;
  localparam int MPROFILE_LSB = 24;
  localparam int SYNC_PRIM_LSB = 20;
  localparam int FENCE_LSB = 16;
  localparam int SECURE_CALL_LSB = 12;
  localparam int WRITEBACK_LSB = 8;
  localparam int SHIFTED_LSB = 4;
  localparam int UNPRIV_LSB = 0;

  // Field values, top field first
  localparam logic [3:0] SWAP_LOCK_VAL = 4'h1;
  localparam logic [3:0] MPROFILE_VAL = 4'h0;
  localparam logic [3:0] SYNC_PRIM_VAL = 4'h0;
  localparam logic [3:0] FENCE_VAL = 4'h1;
  localparam logic [3:0] SECURE_CALL_VAL = 4'h1;
  localparam logic [3:0] WRITEBACK_VAL = 4'h1;
  localparam logic [3:0] SHIFTED_VAL = 4'h4;
  localparam logic [3:0] UNPRIV_VAL = 4'h2;
  localparam logic [7:0][3:0] ISA4_FIELDS = {SWAP_LOCK_VAL, MPROFILE_VAL, SYNC_PRIM_VAL,
    FENCE_VAL, SECURE_CALL_VAL, WRITEBACK_VAL, SHIFTED_VAL, UNPRIV_VAL};
  localparam logic [31:0] ISA4_VALUE = 32'h1001_1142;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] cp_num;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
    logic [1:0] priv;
    logic secure;
    logic [31:0] wdata;
  } cp_req_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic undef;
    logic [31:0] rdata;
  } cp_rsp_t;

  localparam cp_rsp_t RSP_IDLE = '{valid: 1'b0, hit: 1'b0, undef: 1'b0, rdata: 32'h0000_0000};

  // True when the request names this register's coprocessor encoding
  function automatic logic enc_match(input cp_req_t req);
    enc_match = (req.cp_num == CP_NUM) && (req.opc1 == CP_OPC1) && (req.crn == CP_CRN)
      && (req.crm == CP_CRM) && (req.opc2 == CP_OPC2);
  endfunction

  // Privilege level one or higher may touch the register
  function automatic logic priv_ok(input logic [1:0] priv);
    priv_ok = (priv >= PL_ONE);
  endfunction

endpackage
`default_nettype wire

// >>> core/isa_four_fields.sv
// Purpose: Assembles the constant attribute word from its eight fields
// Assumes: Field values are fixed in the package
// Notes: No storage, so neither reset nor writes can alter the word
`timescale 1ns/1ps
`default_nettype none
module isa_four_fields
  import isa_four_pkg::*;
(
  output logic [31:0] value
);

  // One nibble per field; the same word in every build
  genvar g;
  generate
    for (g = 0; g < FIELD_CNT; g++)
    begin : g_field
      assign value[g*FIELD_W +: FIELD_W] = ISA4_FIELDS[g];
    end
  endgenerate

endmodule // isa_four_fields
`default_nettype wire

// >>> core/sysctl_access_check.sv
// Purpose: Decodes a coprocessor access and judges whether it may proceed
// Assumes: Request fields are stable while valid is high
// Notes: Purely combinational; the caller registers the outcome
`timescale 1ns/1ps
`default_nettype none
module sysctl_access_check
  import isa_four_pkg::*;
(
  input wire cp_req_t req,
  output logic hit,
  output logic read_ok,
  output logic refuse
);

  always_comb
  begin
    hit = req.valid && enc_match(req);
    // Security state is deliberately not examined: one shared copy
    read_ok = hit && !req.write && priv_ok(req.priv);
    // A write is never honoured, it is flagged instead
    refuse = hit && (req.write || !priv_ok(req.priv));
  end

endmodule // sysctl_access_check
`default_nettype wire

// >>> core/isa_attribute_id_reg_four.sv
// Purpose: Read-only instruction set attribute register four behind the
//   system control coprocessor access port
// Assumes: One request per cycle at most; inputs synchronous to clk_sys
// Notes: The answer follows each request by exactly one cycle; the register
//   word itself is wired constant and has no flip-flops
//
// How it works
// - Secure and non-secure readers see the same single copy.
// - Access is allowed only at privilege level one or higher.
// - Register is present, unchanged, in every build.
// - Coprocessor fifteen read, opc1 0, c0, c2, opc2 4, returns the word.
// - Bits 31 to 28 read 0x1: swap only in a uniprocessor context.
// - Bits 27 to 24 read 0x0: no m-profile status register operations.
// - Bits 23 to 20 read 0x0: full exclusive load/store family.
// - Bits 19 to 16 read 0x1: all three fence instructions.
// - Bits 15 to 12 read 0x1: secure monitor call present.
// - Bits 11 to 8 read 0x1: all writeback addressing modes.
// - Bits 7 to 4 read 0x4: shifted operand encoding.
// - Bits 3 to 0 read 0x2: unprivileged load/store encoding.
`timescale 1ns/1ps
`default_nettype none
module isa_attribute_id_reg_four
  import isa_four_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire cp_req_t cp_req,
  output var cp_rsp_t cp_rsp
);

  ////////////////////////////////////////////////////////////////////////////
  // Constant word and access decode

  logic [31:0] isa_value;
  logic hit;
  logic read_ok;
  logic refuse;
  cp_rsp_t rsp_reg;
  cp_rsp_t rsp_next;

  isa_four_fields u_fields
  (
    .value (isa_value)
  );

  sysctl_access_check u_check
  (
    .req (cp_req),
    .hit (hit),
    .read_ok (read_ok),
    .refuse (refuse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Answer register

  always_comb
  begin
    rsp_next.valid = cp_req.valid;
    rsp_next.hit = hit;
    rsp_next.undef = refuse;
    // Refused accesses read zero so nothing leaks to unprivileged code
    rsp_next.rdata = read_ok ? isa_value : DATA_ZERO;
  end

  // Reset clears only the answer; the word comes from wiring
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rsp_reg <= RSP_IDLE;
    end
    else
    begin
      rsp_reg <= rsp_next;
    end
  end

  assign cp_rsp = rsp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys);
  endclocking

  default disable iff (rst);

  // Helper: last cycle carried a granted read
  logic good_read_reg;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      good_read_reg <= 1'b0;
    end
    else
    begin
      good_read_reg <= cp_req.valid && enc_match(cp_req) && !cp_req.write
        && priv_ok(cp_req.priv);
    end
  end

  // Helper: last cycle carried a write aimed at this register
  logic write_seen_reg;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      write_seen_reg <= 1'b0;
    end
    else
    begin
      write_seen_reg <= cp_req.valid && enc_match(cp_req) && cp_req.write;
    end
  end

  AST_ONE_CYCLE_ANSWER:
    assert property (cp_req.valid |=> cp_rsp.valid)
    else $error("request not answered in one cycle");

  AST_NO_SPURIOUS_ANSWER:
    assert property (!cp_req.valid |=> !cp_rsp.valid && !cp_rsp.undef)
    else $error("answer without request");

  AST_DECODE_READ:
    assert property (
      cp_req.valid && !cp_req.write && cp_req.priv >= PL_ONE
      && cp_req.cp_num == CP_NUM && cp_req.opc1 == CP_OPC1
      && cp_req.crn == CP_CRN && cp_req.crm == CP_CRM && cp_req.opc2 == CP_OPC2
      |=> cp_rsp.hit && !cp_rsp.undef && cp_rsp.rdata == ISA4_VALUE)
    else $error("matching read did not return the word");

  AST_OTHER_ENCODING_MISSES:
    assert property (
      cp_req.valid && (cp_req.opc2 != CP_OPC2 || cp_req.crm != CP_CRM)
      |=> !cp_rsp.hit && cp_rsp.rdata == DATA_ZERO)
    else $error("foreign encoding claimed");

  AST_SECURE_STATES_SHARE:
    assert property (
      cp_req.valid && enc_match(cp_req) && !cp_req.write && priv_ok(cp_req.priv)
      ##1 cp_req.valid && enc_match(cp_req) && !cp_req.write
      && priv_ok(cp_req.priv) && cp_req.secure != $past(cp_req.secure)
      |=> cp_rsp.rdata == $past(cp_rsp.rdata))
    else $error("secure and non-secure readers see different words");

  AST_PL0_REFUSED:
    assert property (
      cp_req.valid && enc_match(cp_req) && cp_req.priv == PL_ZERO
      |=> cp_rsp.undef && cp_rsp.rdata == DATA_ZERO)
    else $error("privilege level zero access not refused");

  AST_WRITE_IGNORED:
    assert property (
      cp_req.valid && enc_match(cp_req) && cp_req.write
      |=> cp_rsp.undef ##1 (isa_value == ISA4_VALUE))
    else $error("write not refused or word altered");

  AST_WORD_CONSTANT:
    assert property ($stable(isa_value) && isa_value == ISA4_VALUE)
    else $error("attribute word not constant");

  AST_SWAP_FIELD:
    assert property (good_read_reg |-> cp_rsp.rdata[SWAP_LOCK_LSB +: FIELD_W] == 4'h1)
    else $error("swap field wrong");

  AST_MPROFILE_FIELD:
    assert property (good_read_reg |-> cp_rsp.rdata[MPROFILE_LSB +: FIELD_W] == 4'h0)
    else $error("m-profile field wrong");

  AST_SYNC_FIELD:
    assert property (good_read_reg |-> cp_rsp.rdata[SYNC_PRIM_LSB +: FIELD_W] == 4'h0)
    else $error("sync primitive field wrong");

  AST_FENCE_FIELD:
    assert property (good_read_reg |-> cp_rsp.rdata[FENCE_LSB +: FIELD_W] == 4'h1)
    else $error("fence field wrong");

  AST_SECURE_CALL_FIELD:
    assert property (good_read_reg |-> cp_rsp.rdata[SECURE_CALL_LSB +: FIELD_W] == 4'h1)
    else $error("secure monitor call field wrong");

  AST_WRITEBACK_FIELD:
    assert property (good_read_reg |-> cp_rsp.rdata[WRITEBACK_LSB +: FIELD_W] == 4'h1)
    else $error("writeback field wrong");

  AST_SHIFTED_FIELD:
    assert property (good_read_reg |-> cp_rsp.rdata[SHIFTED_LSB +: FIELD_W] == 4'h4)
    else $error("shifted operand field wrong");

  AST_UNPRIV_FIELD:
    assert property (good_read_reg |-> cp_rsp.rdata[UNPRIV_LSB +: FIELD_W] == 4'h2)
    else $error("unprivileged field wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on how the answer fields relate

  AST_HIT_NEEDS_VALID:
    assert property (
      cp_rsp.hit
      |-> cp_rsp.valid)
    else $error("decode hit without a valid answer");

  AST_UNDEF_NEEDS_HIT:
    assert property (
      cp_rsp.undef
      |-> cp_rsp.hit)
    else $error("refusal without a decode hit");

  AST_REFUSAL_READS_ZERO:
    assert property (
      cp_rsp.undef
      |-> cp_rsp.rdata == DATA_ZERO)
    else $error("refused access leaked data");

  AST_MISS_READS_ZERO:
    assert property (
      cp_rsp.valid && !cp_rsp.hit
      |-> !cp_rsp.undef && cp_rsp.rdata == DATA_ZERO)
    else $error("missed access refused or returned data");

  AST_GOOD_READ_FLAGS:
    assert property (
      good_read_reg
      |-> cp_rsp.valid && cp_rsp.hit && !cp_rsp.undef)
    else $error("granted read answered with wrong flags");

  AST_WORD_ONLY_WHEN_GRANTED:
    assert property (
      cp_rsp.rdata != DATA_ZERO
      |-> good_read_reg)
    else $error("word returned without a granted read");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on decode, privilege and security state

  AST_CP_NUM_MISS:
    assert property (
      cp_req.valid && cp_req.cp_num != CP_NUM
      |=> !cp_rsp.hit && !cp_rsp.undef)
    else $error("other coprocessor claimed");

  AST_OPC1_MISS:
    assert property (
      cp_req.valid && cp_req.opc1 != CP_OPC1
      |=> !cp_rsp.hit && !cp_rsp.undef)
    else $error("other first opcode claimed");

  AST_CRN_MISS:
    assert property (
      cp_req.valid && cp_req.crn != CP_CRN
      |=> !cp_rsp.hit && !cp_rsp.undef)
    else $error("other primary register claimed");

  AST_PL1_GRANTED:
    assert property (
      cp_req.valid && enc_match(cp_req) && !cp_req.write && cp_req.priv == PL_ONE
      |=> !cp_rsp.undef && cp_rsp.rdata == ISA4_VALUE)
    else $error("privilege level one read refused");

  AST_HIGHER_PL_GRANTED:
    assert property (
      cp_req.valid && enc_match(cp_req) && !cp_req.write && cp_req.priv > PL_ONE
      |=> !cp_rsp.undef && cp_rsp.rdata == ISA4_VALUE)
    else $error("higher privilege read refused");

  AST_SECURE_READ:
    assert property (
      cp_req.valid && enc_match(cp_req) && !cp_req.write && priv_ok(cp_req.priv)
      && cp_req.secure
      |=> cp_rsp.rdata == ISA4_VALUE)
    else $error("secure reader saw another word");

  AST_NONSECURE_READ:
    assert property (
      cp_req.valid && enc_match(cp_req) && !cp_req.write && priv_ok(cp_req.priv)
      && !cp_req.secure
      |=> cp_rsp.rdata == ISA4_VALUE)
    else $error("non-secure reader saw another word");

  ////////////////////////////////////////////////////////////////////////////
  // Checks that writes and reset leave the word alone

  AST_WRITE_READS_ZERO:
    assert property (
      cp_req.valid && enc_match(cp_req) && cp_req.write
      |=> cp_rsp.hit && cp_rsp.rdata == DATA_ZERO)
    else $error("write answered with data");

  AST_READ_AFTER_WRITE:
    assert property (
      write_seen_reg && cp_req.valid && enc_match(cp_req) && !cp_req.write
      && priv_ok(cp_req.priv)
      |=> cp_rsp.rdata == ISA4_VALUE)
    else $error("write altered the word");

  AST_IDLE_AFTER_RESET:
    assert property (
      $fell(rst)
      |-> !cp_rsp.valid && cp_rsp.rdata == DATA_ZERO)
    else $error("answer pending at reset release");

  AST_FIRST_READ_AFTER_RESET:
    assert property (
      $fell(rst) && cp_req.valid && enc_match(cp_req) && !cp_req.write
      && priv_ok(cp_req.priv)
      |=> cp_rsp.rdata == ISA4_VALUE)
    else $error("reset altered the word");

endmodule // isa_attribute_id_reg_four
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: Self-checking bench for the attribute register four access port
// Assumes: Answer one cycle after each taken request, inputs driven at falling edge
// Notes: Expected field values are written out by hand, not taken from the package
`timescale 1ns/1ps
`default_nettype none
module testbench
  import isa_four_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  cp_req_t cp_req = '0;
  cp_rsp_t cp_rsp;
  int failures = 0;
  int tests_run = 0;

  always #2.5 clk_sys = ~clk_sys;

  isa_attribute_id_reg_four DUT (.clk_sys(clk_sys), .rst(rst), .cp_req(cp_req), .cp_rsp(cp_rsp));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [34:0] seen, input logic [34:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic cp_req_t rd_req(input logic [1:0] pl, input logic sec);
    rd_req = '{valid: 1'b1, write: 1'b0, cp_num: 4'hF, opc1: 3'h0, crn: 4'h0, crm: 4'h2,
      opc2: 3'h4, priv: pl, secure: sec, wdata: 32'hA5A5_5A5A};
  endfunction

  // Caller sits at a falling edge; the answer is settled one falling edge later
  task automatic access(input cp_req_t r, input logic h, input logic u);
    cp_req = r;
    @(negedge clk_sys);
    check("rsp_valid", 35'(cp_rsp.valid), 35'h1);
    check("rsp_hit", 35'(cp_rsp.hit), 35'(h));
    check("rsp_undef", 35'(cp_rsp.undef), 35'(u));
  endtask

  task automatic check_word(input logic [31:0] w);
    check("swap_lock_fraction", 35'(w[31:28]), 35'h1);
    check("status_reg_mprofile_ops", 35'(w[27:24]), 35'h0);
    check("sync_primitive_fraction", 35'(w[23:20]), 35'h0);
    check("fence_ops", 35'(w[19:16]), 35'h1);
    check("secure_monitor_call_ops", 35'(w[15:12]), 35'h1);
    check("writeback_modes", 35'(w[11:8]), 35'h1);
    check("shifted_operand_ops", 35'(w[7:4]), 35'h4);
    check("unpriv_ops", 35'(w[3:0]), 35'h2);
  endtask

  task automatic idle;
    cp_req.valid = 1'b0;
    @(negedge clk_sys);
    check("rsp_idle", 35'(cp_rsp), 35'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Privilege levels one to three and both security states, back to back
  task automatic test_granted_reads;
    for (int pl = 1; pl < 4; pl++)
      for (int s = 0; s < 2; s++)
      begin
        access(rd_req(2'(pl), 1'(s)), 1'b1, 1'b0);
        check_word(cp_rsp.rdata);
      end
    idle();
  endtask

  task automatic test_priv_zero;
    for (int s = 0; s < 2; s++)
    begin
      access(rd_req(2'h0, 1'(s)), 1'b1, 1'b1);
      check("rdata_refused", 35'(cp_rsp.rdata), 35'h0);
    end
    idle();
  endtask

  // A write is followed at once by a read, which must still see the constant word
  task automatic test_write;
    cp_req_t r;
    r = rd_req(2'h3, 1'b0);
    r.write = 1'b1;
    r.wdata = 32'hFFFF_FFFF;
    access(r, 1'b1, 1'b1);
    check("rdata_write", 35'(cp_rsp.rdata), 35'h0);
    access(rd_req(2'h1, 1'b1), 1'b1, 1'b0);
    check_word(cp_rsp.rdata);
    idle();
  endtask

  // One encoding field off at a time, including the neighbouring register three
  task automatic test_miss;
    cp_req_t r;
    for (int i = 0; i < 5; i++)
    begin
      r = rd_req(2'h1, 1'b0);
      case (i)
        0: r.cp_num = 4'hE;
        1: r.opc1 = 3'h1;
        2: r.crn = 4'h1;
        3: r.crm = 4'h1;
        default: r.opc2 = 3'h3;
      endcase
      access(r, 1'b0, 1'b0);
      check("rdata_miss", 35'(cp_rsp.rdata), 35'h0);
    end
    idle();
  endtask

  task automatic test_reset_mid;
    rst = 1'b1;
    cp_req = rd_req(2'h1, 1'b0);
    repeat (2) @(negedge clk_sys);
    check("rsp_in_reset", 35'(cp_rsp), 35'h0);
    rst = 1'b0;
    access(rd_req(2'h1, 1'b0), 1'b1, 1'b0);
    check_word(cp_rsp.rdata);
    idle();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("Checks run %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(negedge clk_sys);
    check("rsp_after_reset", 35'(cp_rsp), 35'h0);
    rst = 1'b0;
    test_granted_reads();
    test_priv_zero();
    test_write();
    test_miss();
    test_reset_mid();
    finish_test();
  end
endmodule // testbench
`default_nettype wire
